// *** hw/crsi_pkg.sv ***
// Shared constants, types and enumerations for the core register file,
// stack pointer and interrupt sequencing logic.
// Assumes one CPU clock and a synchronous active-high system reset.
package crsi_pkg;

    // ****************************************************************
    // Register file geometry and pointer pairs
    // ****************************************************************
    localparam int RF_DEPTH = 32;
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    localparam logic [15:0] DS_RF_END = 16'h0020;

    // ****************************************************************
    // I/O register offsets, bit positions and reset values
    // ****************************************************************
    localparam logic [5:0] IO_IRQ_FLAGS = 6'h30;
    localparam logic [5:0] IO_GEN_IRQ_CTRL = 6'h31;
    localparam logic [5:0] IO_SP_LOW = 6'h32;
    localparam logic [5:0] IO_SP_HIGH = 6'h33;
    localparam logic [5:0] IO_STATUS = 6'h34;
    localparam int GIE_BIT = 7;
    localparam int VSEL_BIT = 1;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] GENERAL_IRQ_CONTROL_REGISTER_RST = 8'h00;
    localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
    localparam logic [15:0] SP_STEP_ADDR = 16'h0002;

    // ****************************************************************
    // Interrupt sources, vectors and sequence lengths
    // ****************************************************************
    localparam int IRQ_N = 8;
    localparam logic [7:0] LEVEL_SRC_MASK = 8'h80;
    localparam logic [12:0] BOOT_START = 13'h1C00;
    localparam logic [12:0] VEC_STRIDE = 13'h0002;
    localparam logic [3:0] ENTRY_CYC = 4'h4;
    localparam logic [3:0] SLEEP_EXTRA_CYC = 4'h4;
    localparam logic [3:0] RETURN_FROM_IRQ_INSTR_CYC = 4'h4;

    // Operation retired by the pipeline at an instruction boundary.
    typedef enum logic [2:0] {
        OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETURN_FROM_IRQ_INSTR, OP_SEI, OP_CLI
    } crsi_op_t;

    // Register file access request from the pipeline.
    typedef struct packed {
        logic we8;
        logic we16;
        logic [4:0] waddr;
        logic [15:0] wdata;
        logic [4:0] ra;
        logic [4:0] rb;
        logic [4:0] rd;
    } crsi_rf_req_t;

endpackage

// *** hw/crsi_regfile.sv ***
// Thirty-two byte working register array with four read ports,
// byte and pair writes, and registered reads with write bypass.
// Assumes the caller resolves write contention before the request.
`timescale 1ns/1ps
module crsi_regfile (
    input wire logic clk, // CPU clock.
    input wire logic rst, // Synchronous reset, active high.
    input crsi_pkg::crsi_rf_req_t req, // Read and write request.
    output logic [7:0] rd_a_q, // Byte operand A.
    output logic [7:0] rd_b_q, // Byte operand B.
    output logic [15:0] rd_w_q, // Pair operand at even index of ra.
    output logic [7:0] rd_d_q, // Data-space read byte.
    output logic [15:0] ptr_x_q, // Pointer X.
    output logic [15:0] ptr_y_q, // Pointer Y.
    output logic [15:0] ptr_z_q // Pointer Z.
);
    import crsi_pkg::*;

    logic [7:0] regs_q [RF_DEPTH];
    logic [7:0] regs_d [RF_DEPTH];
    logic [4:0] pair_lo;
    logic [4:0] pair_hi;

    // Even index of the addressed pair and its odd partner.
    assign pair_lo = {req.ra[4:1], 1'b0};
    assign pair_hi = {req.ra[4:1], 1'b1};

    // ****************************************************************
    // Storage with byte and pair write
    // ****************************************************************
    for (genvar g = 0; g < RF_DEPTH; g++) begin : g_reg
        wire hit8 = req.we8 && (req.waddr == 5'(g));
        wire hitw = req.we16 && (req.waddr[4:1] == 4'(g / 2));
        // Next value of each register; pair writes put low byte even.
        assign regs_d[g] = hit8 ? req.wdata[7:0] :
                           hitw ? ((g % 2 == 0) ? req.wdata[7:0] :
                                   req.wdata[15:8]) : regs_q[g];
        // Each register takes its next value every cycle.
        always_ff @(posedge clk) begin
            if (rst) begin
                regs_q[g] <= 8'h00;
            end else begin
                regs_q[g] <= regs_d[g];
            end
        end
    end

    // ****************************************************************
    // Registered read ports with bypass of the same-cycle write
    // ****************************************************************
    // Reads look at next values so a result is seen without a gap.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_a_q <= 8'h00;
            rd_b_q <= 8'h00;
            rd_w_q <= 16'h0000;
            rd_d_q <= 8'h00;
            ptr_x_q <= 16'h0000;
            ptr_y_q <= 16'h0000;
            ptr_z_q <= 16'h0000;
        end else begin
            rd_a_q <= regs_d[req.ra];
            rd_b_q <= regs_d[req.rb];
            rd_w_q <= {regs_d[pair_hi], regs_d[pair_lo]};
            rd_d_q <= regs_d[req.rd];
            ptr_x_q <= {regs_d[PTR_X_LO + 5'h01], regs_d[PTR_X_LO]};
            ptr_y_q <= {regs_d[PTR_Y_LO + 5'h01], regs_d[PTR_Y_LO]};
            ptr_z_q <= {regs_d[PTR_Z_LO + 5'h01], regs_d[PTR_Z_LO]};
        end
    end

endmodule // crsi_regfile

// *** hw/crsi_top.sv ***
// Core control block: working registers, stack pointer, status
// register and interrupt entry and return sequencing.
// Assumes the pipeline reports each retired instruction on the
// CPU clock and holds off while the stall output is high.
`timescale 1ns/1ps
module crsi_top (
    input wire logic CLK, // CPU clock, 50 MHz.
    input wire logic SYS_RST, // Synchronous reset, active high.
    input wire logic RF_WE8, // Byte result write enable.
    input wire logic RF_WE16, // Pair result write enable.
    input wire logic [4:0] RF_WADDR, // Result register index.
    input wire logic [15:0] RF_WDATA, // Result data.
    input wire logic [4:0] RF_RADDR_A, // Operand A index.
    input wire logic [4:0] RF_RADDR_B, // Operand B index.
    output logic [7:0] RF_RDATA_A, // Operand A, one cycle later.
    output logic [7:0] RF_RDATA_B, // Operand B, one cycle later.
    output logic [15:0] RF_RDATA_W, // Pair operand, one cycle later.
    output logic [15:0] PTR_X, // Pointer X.
    output logic [15:0] PTR_Y, // Pointer Y.
    output logic [15:0] PTR_Z, // Pointer Z.
    input wire logic [15:0] DS_ADDR, // Data-space address.
    input wire logic DS_WE, // Data-space write strobe.
    input wire logic [7:0] DS_WDATA, // Data-space write byte.
    output logic [7:0] DS_RDATA, // Data-space register byte.
    input wire logic [5:0] IO_ADDR, // I/O register address.
    input wire logic IO_WE, // I/O write strobe.
    input wire logic IO_RE, // I/O read strobe.
    input wire logic [7:0] IO_WDATA, // I/O write byte.
    output logic [7:0] IO_RDATA, // I/O read byte.
    input wire logic INSTR_DONE, // Instruction retires this cycle.
    input crsi_pkg::crsi_op_t INSTR_OP, // Kind of retiring instruction.
    input wire logic ALU_FLAG_WE, // Arithmetic flags update.
    input wire logic [6:0] ALU_FLAGS, // New arithmetic flags.
    input wire logic SLEEP_ACTIVE, // Core is asleep.
    input wire logic [12:0] PC, // Current program word address.
    input wire logic APP_LOCK, // Application lock bit programmed.
    input wire logic BOOT_LOCK, // Boot section lock bit programmed.
    input wire logic BOOT_RESET_FUSE, // Reset vector in boot section.
    input wire logic [7:0] IRQ_EVENT, // Flag source event pulses.
    input wire logic [7:0] IRQ_LEVEL, // Level source conditions.
    input wire logic [7:0] IRQ_ENABLE, // Individual enables.
    output logic [15:0] STACK_POINTER, // Stack pointer.
    output logic [7:0] STATUS_REG, // Status register.
    output logic CORE_STALL, // Entry or return in progress.
    output logic VECTOR_VALID, // Pulse: jump to vector now.
    output logic [12:0] VECTOR_ADDR, // Vector of the taken source.
    output logic [12:0] RESET_VECTOR, // Reset vector address.
    output logic [7:0] IRQ_FLAGS // Pending event flags.
);
    import crsi_pkg::*;

    // Sequencer states: running, entering a handler, returning from one.
    typedef enum {ST_RUN, ST_ENTRY, ST_EXIT} crsi_state_t;

    // Registered state and the next values that feed it.
    crsi_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0] status_q, status_d;
    logic [7:0] general_irq_control_register_q;
    logic [7:0] flags_q, flags_d;
    logic shadow_q, shadow_d;
    logic [12:0] vec_q, vec_d;
    logic vec_fire_q;
    logic stall_q;
    logic [12:0] rst_vec_q;
    logic [7:0] io_rdata_q;
    crsi_rf_req_t rf_req;

    // Lowest set index wins; gives index and a valid marker.
    function automatic logic [3:0] pick_lowest(input logic [7:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = {1'b1, 3'(i)};
            end
        end
        return idx;
    endfunction

    // True when an I/O write hits the given address.
    function automatic logic io_wr(input logic we, input logic [5:0] a,
                                   input logic [5:0] reg_a);
        return we && (a == reg_a);
    endfunction

    // ****************************************************************
    // Working registers and data-space mapping
    // ****************************************************************
    // Data-space addresses below the I/O window select the array.
    wire ds_rf_hit = DS_ADDR < DS_RF_END;
    wire ds_rf_wr = DS_WE && ds_rf_hit;

    // Data-space writes to the first 32 addresses go to the array.
    assign rf_req.we8 = RF_WE8 || ds_rf_wr;
    assign rf_req.we16 = RF_WE16 && !ds_rf_wr;
    assign rf_req.waddr = ds_rf_wr ? DS_ADDR[4:0] : RF_WADDR;
    assign rf_req.wdata = ds_rf_wr ? {8'h00, DS_WDATA} : RF_WDATA;
    assign rf_req.ra = RF_RADDR_A;
    assign rf_req.rb = RF_RADDR_B;
    assign rf_req.rd = DS_ADDR[4:0];

    crsi_regfile u_regfile (
        .clk(CLK),
        .rst(SYS_RST),
        .req(rf_req),
        .rd_a_q(RF_RDATA_A),
        .rd_b_q(RF_RDATA_B),
        .rd_w_q(RF_RDATA_W),
        .rd_d_q(DS_RDATA),
        .ptr_x_q(PTR_X),
        .ptr_y_q(PTR_Y),
        .ptr_z_q(PTR_Z)
    );

    // ****************************************************************
    // Interrupt request evaluation
    // ****************************************************************
    // Section of the program counter and where the vectors now sit.
    wire in_boot = PC >= BOOT_START;
    wire vsel = general_irq_control_register_q[VSEL_BIT];
    // Locks block interrupts that would leave a locked section for the other one.
    wire lock_block = (APP_LOCK && !in_boot && vsel) ||
                      (BOOT_LOCK && in_boot && !vsel);
    wire [7:0] flag_src = IRQ_EVENT & ~LEVEL_SRC_MASK;
    wire [7:0] level_req = IRQ_LEVEL & LEVEL_SRC_MASK & IRQ_ENABLE;
    wire [7:0] flag_req = flags_q & IRQ_ENABLE;
    wire [3:0] pick = pick_lowest(flag_req | level_req);
    wire [2:0] pick_idx = pick[2:0];
    wire pick_valid = pick[3];
    wire gie = status_q[GIE_BIT];
    wire boundary = INSTR_DONE || SLEEP_ACTIVE;
    // Retiring disable or enable instructions block a same-cycle entry.
    wire op_blocks = INSTR_DONE && (INSTR_OP == OP_CLI ||
                     INSTR_OP == OP_SEI || INSTR_OP == OP_RETURN_FROM_IRQ_INSTR);
    wire take = (state_q == ST_RUN) && boundary && gie && !shadow_q &&
                !op_blocks && pick_valid && !lock_block;
    wire [12:0] vec_base = vsel ? BOOT_START : 13'h0000;
    // Source n sits one stride past source n-1, after the reset vector.
    wire [12:0] vec_sel = vec_base +
                          VEC_STRIDE * (13'(pick_idx) + 13'h0001);
    wire [3:0] entry_len = SLEEP_ACTIVE ? ENTRY_CYC + SLEEP_EXTRA_CYC :
                           ENTRY_CYC;

    // ****************************************************************
    // Stack pointer arithmetic
    // ****************************************************************
    wire op_now = INSTR_DONE && (state_q == ST_RUN);
    wire [15:0] sp_op = !op_now ? sp_q :
        (INSTR_OP == OP_PUSH) ? sp_q - SP_STEP_BYTE :
        (INSTR_OP == OP_CALL) ? sp_q - SP_STEP_ADDR :
        (INSTR_OP == OP_POP) ? sp_q + SP_STEP_BYTE :
        (INSTR_OP == OP_RET || INSTR_OP == OP_RETURN_FROM_IRQ_INSTR) ?
            sp_q + SP_STEP_ADDR : sp_q;
    // Entry pushes the two-byte return address on top of any op.
    wire [15:0] sp_hw = take ? sp_op - SP_STEP_ADDR : sp_op;

    // Byte writes from software replace one half after hardware moves.
    always_comb begin
        sp_d = sp_hw;
        if (io_wr(IO_WE, IO_ADDR, IO_SP_LOW)) begin
            sp_d[7:0] = IO_WDATA;
        end
        if (io_wr(IO_WE, IO_ADDR, IO_SP_HIGH)) begin
            sp_d[15:8] = IO_WDATA;
        end
    end

    // ****************************************************************
    // Entry and return sequencer
    // ****************************************************************
    // Counts the entry and return windows; return arms the shadow.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        vec_d = vec_q;
        case (state_q)
            ST_RUN: begin
                if (take) begin
                    state_d = ST_ENTRY;
                    cnt_d = entry_len - 4'h1;
                    vec_d = vec_sel;
                end else if (op_now && INSTR_OP == OP_RETURN_FROM_IRQ_INSTR) begin
                    state_d = ST_EXIT;
                    cnt_d = RETURN_FROM_IRQ_INSTR_CYC - 4'h1;
                end
            end
            ST_ENTRY, ST_EXIT: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_RUN;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Last cycle of each window, for the shadow and the vector strobe.
    wire exit_end = (state_q == ST_EXIT) && (cnt_q == 4'h0);
    wire entry_end = (state_q == ST_ENTRY) && (cnt_q == 4'h0);

    // Shadow holds off entry for exactly one retired instruction.
    always_comb begin
        shadow_d = shadow_q;
        if (INSTR_DONE && state_q == ST_RUN) begin
            shadow_d = 1'b0;
        end
        if (exit_end || (op_now && INSTR_OP == OP_SEI && !gie)) begin
            shadow_d = 1'b1;
        end
    end

    // ****************************************************************
    // Status register and pending flags
    // ****************************************************************
    // Only the global enable is touched by entry and return.
    always_comb begin
        status_d = status_q;
        if (ALU_FLAG_WE) begin
            status_d[6:0] = ALU_FLAGS;
        end
        if (io_wr(IO_WE, IO_ADDR, IO_STATUS)) begin
            status_d = IO_WDATA;
        end
        if (op_now && INSTR_OP == OP_SEI) begin
            status_d[GIE_BIT] = 1'b1;
        end
        if (op_now && INSTR_OP == OP_CLI) begin
            status_d[GIE_BIT] = 1'b0;
        end
        if (take) begin
            status_d[GIE_BIT] = 1'b0;
        end
        if (exit_end) begin
            status_d[GIE_BIT] = 1'b1;
        end
    end

    // Clears by vectoring or by writing one; a new event wins.
    always_comb begin
        flags_d = flags_q;
        if (io_wr(IO_WE, IO_ADDR, IO_IRQ_FLAGS)) begin
            flags_d = flags_d & ~IO_WDATA;
        end
        if (take) begin
            flags_d[pick_idx] = 1'b0;
        end
        flags_d = flags_d | flag_src;
    end

    // ****************************************************************
    // I/O read mux
    // ****************************************************************
    // Read data of the mapped I/O registers; other offsets read zero.
    wire [7:0] io_mux = (IO_ADDR == IO_SP_LOW) ? sp_q[7:0] :
                        (IO_ADDR == IO_SP_HIGH) ? sp_q[15:8] :
                        (IO_ADDR == IO_STATUS) ? status_q :
                        (IO_ADDR == IO_GEN_IRQ_CTRL) ? general_irq_control_register_q :
                        (IO_ADDR == IO_IRQ_FLAGS) ? flags_q : 8'h00;

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Control state, stack pointer and status register.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q <= ST_RUN;
            cnt_q <= 4'h0;
            sp_q <= SP_RST;
            status_q <= STATUS_RST;
            shadow_q <= 1'b0;
            flags_q <= 8'h00;
            vec_q <= 13'h0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sp_q <= sp_d;
            status_q <= status_d;
            shadow_q <= shadow_d;
            flags_q <= flags_d;
            vec_q <= vec_d;
        end
    end

    // Control register, output strobes and the reset vector capture.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            general_irq_control_register_q <= GENERAL_IRQ_CONTROL_REGISTER_RST;
            vec_fire_q <= 1'b0;
            stall_q <= 1'b0;
            io_rdata_q <= 8'h00;
            rst_vec_q <= BOOT_RESET_FUSE ? BOOT_START : 13'h0000;
        end else begin
            if (io_wr(IO_WE, IO_ADDR, IO_GEN_IRQ_CTRL)) begin
                general_irq_control_register_q <= IO_WDATA;
            end
            vec_fire_q <= entry_end;
            stall_q <= (state_d != ST_RUN);
            io_rdata_q <= IO_RE ? io_mux : io_rdata_q;
        end
    end

    // Every output is a register; these assignments only rename them.
    assign STACK_POINTER = sp_q;
    assign STATUS_REG = status_q;
    assign CORE_STALL = stall_q;
    assign VECTOR_VALID = vec_fire_q;
    assign VECTOR_ADDR = vec_q;
    assign RESET_VECTOR = rst_vec_q;
    assign IRQ_FLAGS = flags_q;
    assign IO_RDATA = io_rdata_q;

endmodule // crsi_top

// *** test/crsi_pipe_model.sv ***
// Retire gate standing in for the execution pipeline.
// Assumes the bench holds a request until the gate lets it through.
`timescale 1ns/1ps
module crsi_pipe_model (
    input wire logic req, // Retire request.
    input wire logic stall, // Core stall.
    output logic done // Retire strobe.
);
    // Nothing retires while entry or return owns the core.
    assign done = req & ~stall;
endmodule // crsi_pipe_model

// *** test/crsi_top_sva.sv ***
// Port assertions for the core control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module crsi_top_sva (
    input wire logic CLK, // Clock.
    input wire logic SYS_RST, // Reset.
    input wire logic INSTR_DONE, // Retire strobe.
    input crsi_pkg::crsi_op_t INSTR_OP, // Retiring kind.
    input wire logic IO_WE, // I/O write.
    input wire logic [15:0] STACK_POINTER, // Stack pointer.
    input wire logic [7:0] STATUS_REG, // Status.
    input wire logic CORE_STALL, // Stall.
    input wire logic VECTOR_VALID // Vector pulse.
);
    import crsi_pkg::*;
    // Retire edges free of I/O writes, and those with interrupts off.
    wire logic gie = STATUS_REG[GIE_BIT];
    wire logic go = INSTR_DONE & ~CORE_STALL & ~IO_WE;
    wire logic quiet = go & ~gie;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    reset_val_a: assert property (
        $fell(SYS_RST) |-> STACK_POINTER == SP_RST && STATUS_REG == STATUS_RST)
        else $error("State not cleared by reset.");
    sp_push_a: assert property (
        quiet && INSTR_OP == OP_PUSH |=>
        STACK_POINTER == $past(STACK_POINTER) - SP_STEP_BYTE)
        else $error("Push moved the stack pointer wrongly.");
    sp_call_a: assert property (
        quiet && INSTR_OP == OP_CALL |=>
        STACK_POINTER == $past(STACK_POINTER) - SP_STEP_ADDR)
        else $error("Call moved the stack pointer wrongly.");
    sp_ret_a: assert property (
        quiet && INSTR_OP == OP_RET |=>
        STACK_POINTER == $past(STACK_POINTER) + SP_STEP_ADDR)
        else $error("Return moved the stack pointer wrongly.");
    return_from_irq_instr_seq_a: assert property (
        go && INSTR_OP == OP_RETURN_FROM_IRQ_INSTR |=> STACK_POINTER ==
        $past(STACK_POINTER) + SP_STEP_ADDR ##0 CORE_STALL [*4] ##1 gie)
        else $error("Interrupt return sequence wrong.");
    cli_now_a: assert property (
        go && INSTR_OP == OP_CLI |=> !CORE_STALL && !gie)
        else $error("Interrupt taken on disable.");
    vec_stall_a: assert property (
        VECTOR_VALID |->
        !CORE_STALL && $past(CORE_STALL, 1) && $past(CORE_STALL, 4))
        else $error("Entry shorter than four cycles.");
    gie_gate_a: assert property (
        VECTOR_VALID && !$past(CORE_STALL, 5) |-> $past(gie, 5) && !gie)
        else $error("Entry without global enable.");
    // Main scenarios reached.
    cover property (VECTOR_VALID);
    cover property (go && INSTR_OP == OP_RETURN_FROM_IRQ_INSTR);
    cover property (quiet && INSTR_OP == OP_PUSH);
endmodule // crsi_top_sva

bind crsi_top crsi_top_sva u_sva (.CLK(CLK), .SYS_RST(SYS_RST),
    .INSTR_DONE(INSTR_DONE), .INSTR_OP(INSTR_OP), .IO_WE(IO_WE),
    .STACK_POINTER(STACK_POINTER), .STATUS_REG(STATUS_REG),
    .CORE_STALL(CORE_STALL), .VECTOR_VALID(VECTOR_VALID));

// *** test/crsi_top_test.sv ***
// Self-checking bench for the core control block.
// Assumes the package, design, retire gate and checker are compiled.
`timescale 1ns/1ps
module crsi_top_test;
    import crsi_pkg::*;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic req = 1'b0;
    logic RF_WE8, RF_WE16, DS_WE, IO_WE, IO_RE, INSTR_DONE, ALU_FLAG_WE;
    logic SLEEP_ACTIVE, APP_LOCK, BOOT_LOCK, BOOT_RESET_FUSE;
    logic CORE_STALL, VECTOR_VALID;
    logic [4:0] RF_WADDR, RF_RADDR_A, RF_RADDR_B;
    logic [5:0] IO_ADDR;
    logic [6:0] ALU_FLAGS;
    logic [7:0] RF_RDATA_A, RF_RDATA_B, DS_WDATA, DS_RDATA, IO_WDATA;
    logic [7:0] IO_RDATA, IRQ_EVENT, IRQ_LEVEL, IRQ_ENABLE, STATUS_REG;
    logic [7:0] IRQ_FLAGS;
    logic [12:0] PC, VECTOR_ADDR, RESET_VECTOR;
    logic [15:0] RF_WDATA, RF_RDATA_W, PTR_X, PTR_Y, PTR_Z, DS_ADDR;
    logic [15:0] STACK_POINTER;
    crsi_op_t INSTR_OP;
    crsi_op_t ops [4] = '{OP_PUSH, OP_CALL, OP_POP, OP_RET};
    logic [15:0] sps [4] = '{16'h00FF, 16'h00FD, 16'h00FE, 16'h0100};
    int miscompares = 0;
    int samples_checked = 0;
    int n;

    // Design, retire gate and the 50 MHz clock.
    crsi_top u_dut (.*);
    crsi_pipe_model u_pipe (.req(req), .stall(CORE_STALL),
        .done(INSTR_DONE));
    always #10 CLK = ~CLK;

    // Compares one result and counts it.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One I/O cycle, a write when wr is set and a read otherwise.
    task automatic io(input logic [5:0] a, input logic [7:0] d,
                      input logic wr);
        @(negedge CLK);
        {IO_ADDR, IO_WDATA, IO_WE, IO_RE} = {a, d, wr, ~wr};
        @(negedge CLK);
        {IO_WE, IO_RE} = 2'h0;
    endtask

    // Register write with both operand ports aimed at the same index.
    task automatic rf(input logic w16, input logic [4:0] a,
                      input logic [15:0] d);
        @(negedge CLK);
        {RF_WE8, RF_WE16, RF_WADDR, RF_WDATA} = {~w16, w16, a, d};
        {RF_RADDR_A, RF_RADDR_B} = {a, a};
        @(negedge CLK);
        {RF_WE8, RF_WE16} = 2'h0;
    endtask

    // Retires one instruction once the core stops stalling.
    task automatic retire(input crsi_op_t op);
        @(negedge CLK);
        req = 1'b1;
        INSTR_OP = op;
        while (CORE_STALL) @(negedge CLK);
        @(negedge CLK);
        req = 1'b0;
    endtask

    // Counts stall cycles until the core is free.
    task automatic settle();
        n = 0;
        while (CORE_STALL && n < 20) begin
            n++;
            @(negedge CLK);
        end
    endtask

    // One-cycle event pulse from the interrupt sources.
    task automatic ev(input logic [7:0] m);
        @(negedge CLK);
        IRQ_EVENT = m;
        @(negedge CLK);
        IRQ_EVENT = 8'h00;
    endtask

    // Prints the verdict and ends the run.
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence.
    initial begin
        {RF_WE8, RF_WE16, DS_WE, IO_WE, IO_RE, ALU_FLAG_WE} = 6'h00;
        {SLEEP_ACTIVE, APP_LOCK, BOOT_LOCK, BOOT_RESET_FUSE} = 4'h0;
        {RF_WADDR, RF_RADDR_A, RF_RADDR_B, RF_WDATA} = 31'h0;
        {DS_ADDR, DS_WDATA, IO_ADDR, IO_WDATA} = 38'h0;
        {IRQ_EVENT, IRQ_LEVEL, IRQ_ENABLE, ALU_FLAGS} = 31'h0;
        PC = 13'h0100;
        INSTR_OP = OP_NONE;
        repeat (8) @(negedge CLK);
        SYS_RST = 1'b0;
        chk(STACK_POINTER, SP_RST);
        chk(STATUS_REG, STATUS_RST);
        chk(RESET_VECTOR, 13'h0000);
        io(IO_SP_HIGH, 8'h00, 1'b0);
        chk(IO_RDATA, 8'h00);
        rf(1'b0, 5'h05, 16'h00AB);
        chk(RF_RDATA_A, 8'hAB);
        chk(RF_RDATA_B, 8'hAB);
        rf(1'b1, PTR_X_LO, 16'h1234);
        chk(RF_RDATA_W, 16'h1234);
        rf(1'b1, PTR_Y_LO, 16'hBEEF);
        chk(PTR_Y, 16'hBEEF);
        {DS_ADDR, DS_WDATA, DS_WE} = {16'h001F, 8'h5A, 1'b1};
        @(negedge CLK);
        {DS_ADDR, DS_WE} = {16'h001A, 1'b0};
        @(negedge CLK);
        chk(DS_RDATA, 8'h34);
        chk(PTR_X, 16'h1234);
        chk(PTR_Z[15:8], 8'h5A);
        io(IO_SP_HIGH, 8'h01, 1'b1);
        io(IO_SP_LOW, 8'h00, 1'b1);
        foreach (ops[i]) begin
            retire(ops[i]);
            chk(STACK_POINTER, sps[i]);
        end
        io(IO_SP_HIGH, 8'h00, 1'b0);
        chk(IO_RDATA, 8'h01);
        {ALU_FLAG_WE, ALU_FLAGS, IRQ_ENABLE} = {1'b1, 7'h55, 8'h24};
        ev(8'h24);
        ALU_FLAG_WE = 1'b0;
        chk(IRQ_FLAGS, 8'h24);
        io(IO_IRQ_FLAGS, 8'h20, 1'b1);
        chk(IRQ_FLAGS, 8'h04);
        ev(8'h20);
        retire(OP_SEI);
        retire(OP_NONE);
        chk(CORE_STALL, 1'b0);
        retire(OP_NONE);
        settle();
        chk(n, 16'h0004);
        chk(VECTOR_VALID, 1'b1);
        chk(VECTOR_ADDR, VEC_STRIDE * 3);
        chk(IRQ_FLAGS, 8'h20);
        chk(STATUS_REG, 8'h55);
        chk(STACK_POINTER, 16'h00FE);
        retire(OP_RETURN_FROM_IRQ_INSTR);
        chk(STACK_POINTER, 16'h0100);
        settle();
        chk(n, 16'h0004);
        chk(STATUS_REG, 8'hD5);
        retire(OP_NONE);
        chk(CORE_STALL, 1'b0);
        retire(OP_NONE);
        settle();
        chk(VECTOR_ADDR, VEC_STRIDE * 6);
        IRQ_ENABLE = 8'hA4;
        ev(8'h04);
        io(IO_STATUS, 8'h80, 1'b1);
        retire(OP_CLI);
        chk(CORE_STALL, 1'b0);
        chk(STATUS_REG, 8'h00);
        io(IO_IRQ_FLAGS, 8'h04, 1'b1);
        io(IO_GEN_IRQ_CTRL, 8'h02, 1'b1);
        IRQ_LEVEL = 8'h80;
        io(IO_STATUS, 8'h80, 1'b1);
        IRQ_LEVEL = 8'h00;
        retire(OP_NONE);
        chk(CORE_STALL, 1'b0);
        IRQ_LEVEL = 8'h80;
        retire(OP_NONE);
        settle();
        chk(VECTOR_ADDR, BOOT_START + VEC_STRIDE * 8);
        APP_LOCK = 1'b1;
        io(IO_STATUS, 8'h80, 1'b1);
        retire(OP_NONE);
        chk(CORE_STALL, 1'b0);
        APP_LOCK = 1'b0;
        SLEEP_ACTIVE = 1'b1;
        @(negedge CLK);
        settle();
        chk(n, 16'h0008);
        chk(VECTOR_VALID, 1'b1);
        SLEEP_ACTIVE = 1'b0;
        SYS_RST = 1'b1;
        BOOT_RESET_FUSE = 1'b1;
        repeat (2) @(negedge CLK);
        SYS_RST = 1'b0;
        @(negedge CLK);
        chk(RESET_VECTOR, BOOT_START);
        chk(STACK_POINTER, SP_RST);
        conclude();
    end

    // Watchdog: the sequence needs about a hundred cycles, 1000 are allowed.
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
endmodule // crsi_top_test
